/* logic/axf_pkg.sv */
// package: constants, types and register map of the axis status flag block
package axf_pkg;
    // apb register byte offsets
    localparam logic [7:0] AXF_CTRL_OFS = 8'h00;
    localparam logic [7:0] AXF_AX1_CFG_OFS = 8'h04;
    localparam logic [7:0] AXF_AX2_CFG_OFS = 8'h08;
    localparam logic [7:0] AXF_MODE_OFS = 8'h0c;
    localparam logic [7:0] AXF_STATUS_OFS = 8'h10;
    localparam logic [7:0] AXF_AX1_CODE_OFS = 8'h14;
    localparam logic [7:0] AXF_AX2_CODE_OFS = 8'h18;

    // field positions
    localparam int AXF_CFG_DWELL_LSB = 0;   // dwell time, ms, 16 bits
    localparam int AXF_CFG_CPLT_LSB = 16;   // complete output time, ms, 16 bits
    localparam int AXF_STATUS_STRIDE = 8;   // flag byte per axis in status
    localparam int AXF_CODE_ERR_LSB = 0;
    localparam int AXF_CODE_WARN_LSB = 16;

    // reset values
    localparam logic [15:0] AXF_DWELL_RST = 16'h0000;
    localparam logic [15:0] AXF_CPLT_RST = 16'h012c;
    localparam logic [1:0] AXF_MODE_RST = 2'h0;

    // error and warning codes
    localparam logic [15:0] AXF_ERR_AUX_START = 16'd536;
    localparam logic [15:0] AXF_WARN_AUX_HELD = 16'd503;

    // timing
    localparam int AXF_CLK_KHZ = 125000;
    localparam int AXF_MS_US = 1000;
    localparam int AXF_SLOW_PERIOD_US = 56800;
    localparam int AXF_MS_CYC = AXF_CLK_KHZ;  // clock cycles in one millisecond
    localparam int AXF_SLOW_CYC = AXF_SLOW_PERIOD_US * (AXF_CLK_KHZ / 1000);

    // kind of operation that the motion core starts
    typedef enum logic [2:0] {
        AXF_OP_POS = 3'b000,
        AXF_OP_ZRET = 3'b001,
        AXF_OP_JOG = 3'b010,
        AXF_OP_MPG = 3'b011,
        AXF_OP_STEP = 3'b100
    } axf_op_t;

    // events and levels from the motion core, one set per axis
    typedef struct packed {
        logic op_start;         // pulse: an operation began
        axf_op_t op_kind;       // kind of that operation
        logic entry_start;      // pulse: a data entry began
        logic [15:0] aux_code;  // aux code value of that entry
        logic entry_done;       // pulse: entry reached its target
        logic entry_speed;      // entry was speed control
        logic cont_path;        // entry under continuous path control
        logic stopped;          // pulse: normal stop reached
        logic step_halt;        // pulse: halted in step operation
        logic abort;            // pulse: ended by error or stop command
        logic error_event;      // pulse: error detected
        logic [15:0] error_code;
        logic over_limit;       // level: command above speed limit
        logic speed_change;     // level: speed change processing
    } axf_motion_t;

    // flags reported to the master, one set per axis
    typedef struct packed {
        logic start_ack;
        logic busy;
        logic pos_complete;
        logic error_flag;
        logic aux_code_present;
        logic speed_limiting;
        logic speed_change;
        logic warning;
    } axf_flags_t;
endpackage : axf_pkg

/* logic/axf_status_flags.sv */
// axis status flag logic for a two-axis positioning controller, with apb registers
//
// Operation
// - start ack rises once start request is high and positioning has begun
// - start ack also rises for a machine zero-point return start
// - master drops request after ack; ack falls when request goes low
// - busy rises on move, return or jog start; falls after dwell following stop
// - busy falls at once when the axis halts in step operation
// - in pulse generator mode busy follows the pulse generator enable
// - outside pulse generator mode, busy falls when the axis ends on error or stop command
// - zero-length moves still pulse busy, perhaps too briefly to see
// - complete flag stands for the output time per entry; never when zero
// - any new start clears a still-active complete flag immediately
// - no complete flag after speed control or a cancelled move
// - error flag sets on detected error and holds until error reset
// - aux flag rises at entry start in concurrent mode, at completion otherwise
// - master raises clear request; aux flag clears on its rising edge
// - aux flag stays low when the entry's aux code is zero
// - continuous path keeps moving with aux flag held but raises warning 503
// - aux flag clears whenever remote station ready goes low
// - a start while aux flag is high is refused with error 536
// - speed-limiting flag high while commanded speed exceeds the limit
// - speed-limiting flag clears when speed within limit or axis stopped
// - speed-change flag high exactly during speed change processing
// - slow flags refresh every 56.8 ms; short events may be missed
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module axf_status_flags
    import axf_pkg::*;
#(
    parameter int MS_CYC = AXF_MS_CYC,
    parameter int SLOW_CYC = AXF_SLOW_CYC,
    parameter int AXES = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // remote bits from the master, asynchronous to pclk
    input wire logic [AXES-1:0] start_request,
    input wire logic [AXES-1:0] aux_code_clear_req,
    input wire logic [AXES-1:0] mpg_enable,
    input wire logic station_ready,
    // motion core, same clock
    input wire axf_motion_t [AXES-1:0] motion,
    output logic [AXES-1:0] start_go,
    output logic [AXES-1:0] start_allowed,
    // flags to the master
    output axf_flags_t [AXES-1:0] flags
);
    localparam int NSYNC = 3 * AXES + 1;

    // decode of an apb offset, used by write and read paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // ---------------------------------------------------------------------
    // three-stage synchronisers; a change counts once stages two and three agree
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] sync3_reg;
    logic [NSYNC-1:0] clean_reg;
    logic [NSYNC-1:0] clean_prev_reg;

    assign raw_in = {station_ready, mpg_enable, aux_code_clear_req, start_request};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // filtered level; a one-stage disagreement leaves the old value standing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clean_reg <= '0;
            clean_prev_reg <= '0;
        end else begin
            for (int i = 0; i < NSYNC; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    clean_reg[i] <= sync3_reg[i];
                end
            end
            clean_prev_reg <= clean_reg;
        end
    end

    logic ready_level;
    assign ready_level = clean_reg[NSYNC-1];

    // ---------------------------------------------------------------------
    // time bases: millisecond tick for dwell and output time, slow refresh tick
    logic [$clog2(MS_CYC)-1:0] ms_cnt_reg;
    logic [$clog2(SLOW_CYC)-1:0] slow_cnt_reg;
    logic ms_tick;
    logic slow_tick;

    assign ms_tick = (ms_cnt_reg == ($clog2(MS_CYC))'(MS_CYC - 1));
    assign slow_tick = (slow_cnt_reg == ($clog2(SLOW_CYC))'(SLOW_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_reg <= '0;
        end else if (ms_tick) begin
            ms_cnt_reg <= '0;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 1'b1;
        end
    end

    // free-running refresh period for the slow flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt_reg <= '0;
        end else if (slow_tick) begin
            slow_cnt_reg <= '0;
        end else begin
            slow_cnt_reg <= slow_cnt_reg + 1'b1;
        end
    end

    // ---------------------------------------------------------------------
    // apb registers; zero wait states, unmapped offsets answer with pslverr
    logic [15:0] dwell_time_setting_reg [AXES];
    logic [15:0] cplt_time_reg [AXES];
    logic [AXES-1:0] aux_after_mode_reg;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [AXES-1:0] err_reset;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign mapped = hit(paddr, AXF_CTRL_OFS) || hit(paddr, AXF_AX1_CFG_OFS)
        || hit(paddr, AXF_AX2_CFG_OFS) || hit(paddr, AXF_MODE_OFS)
        || hit(paddr, AXF_STATUS_OFS) || hit(paddr, AXF_AX1_CODE_OFS)
        || hit(paddr, AXF_AX2_CODE_OFS);
    assign pslverr = psel && penable && !mapped;
    // writing a one to a control bit resets that axis's error
    assign err_reset = (wr_en && hit(paddr, AXF_CTRL_OFS)) ? pwdata[AXES-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int a = 0; a < AXES; a++) begin
                dwell_time_setting_reg[a] <= AXF_DWELL_RST;
                cplt_time_reg[a] <= AXF_CPLT_RST;
            end
            aux_after_mode_reg <= AXF_MODE_RST;
        end else if (wr_en) begin
            if (hit(paddr, AXF_AX1_CFG_OFS)) begin
                dwell_time_setting_reg[0] <= pwdata[AXF_CFG_DWELL_LSB +: 16];
                cplt_time_reg[0] <= pwdata[AXF_CFG_CPLT_LSB +: 16];
            end
            if (hit(paddr, AXF_AX2_CFG_OFS)) begin
                dwell_time_setting_reg[1] <= pwdata[AXF_CFG_DWELL_LSB +: 16];
                cplt_time_reg[1] <= pwdata[AXF_CFG_CPLT_LSB +: 16];
            end
            if (hit(paddr, AXF_MODE_OFS)) begin
                aux_after_mode_reg <= pwdata[AXES-1:0];
            end
        end
    end

    // ---------------------------------------------------------------------
    // per-axis flag logic, each axis fully independent
    logic [15:0] err_code_reg [AXES];
    logic [15:0] warn_code_reg [AXES];

    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            logic req_level;
            logic req_rise;
            logic clr_rise;
            logic mpg_level;
            logic start_ack_reg;
            logic busy_reg;
            logic mpg_mode_reg;
            logic dwell_run_reg;
            logic [15:0] dwell_cnt_reg;
            logic cplt_reg;
            logic [15:0] cplt_cnt_reg;
            logic aux_reg;
            logic [15:0] aux_code_reg;
            logic err_reg;
            logic warn_reg;
            logic limit_reg;
            logic moving_reg;
            logic refused;
            logic any_start;
            logic aux_set;
            logic cplt_event;

            assign req_level = clean_reg[g];
            assign req_rise = clean_reg[g] && !clean_prev_reg[g];
            assign clr_rise = clean_reg[AXES + g] && !clean_prev_reg[AXES + g];
            assign mpg_level = clean_reg[2 * AXES + g];
            assign any_start = motion[g].op_start;
            // a start asked for while the aux flag stands is refused
            assign refused = req_rise && aux_reg;
            assign start_go[g] = req_rise && !aux_reg && !busy_reg;
            assign start_allowed[g] = !aux_reg;
            // completion only for an entry that reached its target
            assign cplt_event = motion[g].entry_done && !motion[g].entry_speed;

            // start acknowledge follows the start request
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    start_ack_reg <= 1'b0;
                end else if (!req_level) begin
                    start_ack_reg <= 1'b0;
                end else if (any_start && (motion[g].op_kind == AXF_OP_POS
                        || motion[g].op_kind == AXF_OP_ZRET)) begin
                    start_ack_reg <= 1'b1;
                end
            end

            // busy, with dwell countdown after a normal stop
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    busy_reg <= 1'b0;
                    mpg_mode_reg <= 1'b0;
                    dwell_run_reg <= 1'b0;
                    dwell_cnt_reg <= '0;
                end else if (any_start) begin
                    // a zero-length move still shows at least one busy cycle
                    mpg_mode_reg <= (motion[g].op_kind == AXF_OP_MPG);
                    busy_reg <= (motion[g].op_kind != AXF_OP_MPG) || mpg_level;
                    dwell_run_reg <= 1'b0;
                end else if (mpg_mode_reg) begin
                    busy_reg <= mpg_level;
                    mpg_mode_reg <= mpg_level;
                end else if (motion[g].abort || motion[g].step_halt) begin
                    busy_reg <= 1'b0;
                    dwell_run_reg <= 1'b0;
                end else if (motion[g].stopped && busy_reg) begin
                    dwell_cnt_reg <= dwell_time_setting_reg[g];
                    dwell_run_reg <= (dwell_time_setting_reg[g] != 16'h0000);
                    busy_reg <= (dwell_time_setting_reg[g] != 16'h0000);
                end else if (dwell_run_reg && ms_tick) begin
                    if (dwell_cnt_reg <= 16'h0001) begin
                        busy_reg <= 1'b0;
                        dwell_run_reg <= 1'b0;
                    end
                    dwell_cnt_reg <= dwell_cnt_reg - 16'h0001;
                end
            end

            // positioning complete, timed in milliseconds
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cplt_reg <= 1'b0;
                    cplt_cnt_reg <= '0;
                end else if (any_start) begin
                    cplt_reg <= 1'b0;
                end else if (cplt_event) begin
                    cplt_reg <= (cplt_time_reg[g] != 16'h0000);
                    cplt_cnt_reg <= cplt_time_reg[g];
                end else if (cplt_reg && ms_tick) begin
                    if (cplt_cnt_reg <= 16'h0001) begin
                        cplt_reg <= 1'b0;
                    end
                    cplt_cnt_reg <= cplt_cnt_reg - 16'h0001;
                end
            end

            // aux code flag; a set in the same cycle as a clear wins
            assign aux_set = aux_after_mode_reg[g]
                ? (motion[g].entry_done && aux_code_reg != 16'h0000)
                : (motion[g].entry_start && motion[g].aux_code != 16'h0000);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    aux_reg <= 1'b0;
                    aux_code_reg <= '0;
                end else begin
                    if (motion[g].entry_start) begin
                        aux_code_reg <= motion[g].aux_code;
                    end
                    if (aux_set) begin
                        aux_reg <= 1'b1;
                    end else if (clr_rise || !ready_level) begin
                        aux_reg <= 1'b0;
                    end
                end
            end

            // error flag and codes; a new error wins over a reset in the same cycle
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    err_reg <= 1'b0;
                    err_code_reg[g] <= '0;
                end else if (motion[g].error_event) begin
                    err_reg <= 1'b1;
                    err_code_reg[g] <= motion[g].error_code;
                end else if (refused) begin
                    err_reg <= 1'b1;
                    err_code_reg[g] <= AXF_ERR_AUX_START;
                end else if (err_reset[g]) begin
                    err_reg <= 1'b0;
                    err_code_reg[g] <= '0;
                end
            end

            // motion goes on under continuous path; only a warning is raised
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    warn_reg <= 1'b0;
                    warn_code_reg[g] <= '0;
                end else if (motion[g].entry_start && motion[g].cont_path && aux_reg) begin
                    warn_reg <= 1'b1;
                    warn_code_reg[g] <= AXF_WARN_AUX_HELD;
                end else if (err_reset[g]) begin
                    warn_reg <= 1'b0;
                    warn_code_reg[g] <= '0;
                end
            end

            // speed limiting, refreshed only on the slow tick
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    moving_reg <= 1'b0;
                    limit_reg <= 1'b0;
                end else begin
                    if (any_start) begin
                        moving_reg <= 1'b1;
                    end else if (motion[g].stopped || motion[g].abort
                            || motion[g].step_halt) begin
                        moving_reg <= 1'b0;
                    end
                    if (slow_tick) begin
                        limit_reg <= motion[g].over_limit && moving_reg;
                    end
                end
            end

            // flags out; speed change follows its processing directly
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags[g] <= '0;
                end else begin
                    flags[g].start_ack <= start_ack_reg;
                    flags[g].busy <= busy_reg;
                    flags[g].pos_complete <= cplt_reg;
                    flags[g].error_flag <= err_reg;
                    flags[g].aux_code_present <= aux_reg;
                    flags[g].speed_limiting <= limit_reg;
                    flags[g].speed_change <= motion[g].speed_change;
                    flags[g].warning <= warn_reg;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------------
    // read mux, registered so data leaves from flip-flops
    logic [31:0] rd_next;

    always_comb begin
        rd_next = '0;
        if (hit(paddr, AXF_AX1_CFG_OFS)) begin
            rd_next = {cplt_time_reg[0], dwell_time_setting_reg[0]};
        end else if (hit(paddr, AXF_AX2_CFG_OFS)) begin
            rd_next = {cplt_time_reg[1], dwell_time_setting_reg[1]};
        end else if (hit(paddr, AXF_MODE_OFS)) begin
            rd_next = {30'h0, aux_after_mode_reg};
        end else if (hit(paddr, AXF_STATUS_OFS)) begin
            rd_next = {16'h0, flags[1], flags[0]};
        end else if (hit(paddr, AXF_AX1_CODE_OFS)) begin
            rd_next = {warn_code_reg[0], err_code_reg[0]};
        end else if (hit(paddr, AXF_AX2_CODE_OFS)) begin
            rd_next = {warn_code_reg[1], err_code_reg[1]};
        end
    end

    // captured in the setup phase so zero-wait access phase returns it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_next;
        end
    end
endmodule : axf_status_flags

/* bench/axf_core_model.sv */
// motion core model: answers each start pulse with a move of run_len edges
`timescale 1ns/1ps
module axf_core_model
    import axf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] start_go,
    input wire axf_motion_t [1:0] inj,
    input wire logic [7:0] run_len,
    output axf_motion_t [1:0] motion
);
    axf_motion_t [1:0] gen_reg;
    logic [1:0][7:0] cnt_reg;
    // bench events and levels are merged in, so scenarios can add errors at any time
    assign motion = gen_reg | inj;
    // a start is answered one edge later; done and stop come together, never a zero-length run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_reg <= '0;
            cnt_reg <= '0;
        end else begin
            for (int a = 0; a < 2; a++) begin
                gen_reg[a].op_start <= start_go[a];
                gen_reg[a].entry_start <= start_go[a];
                gen_reg[a].entry_done <= cnt_reg[a] == 8'h01;
                gen_reg[a].stopped <= cnt_reg[a] == 8'h01;
                cnt_reg[a] <= start_go[a] ? run_len : cnt_reg[a] - 8'(cnt_reg[a] != 8'h00);
            end
        end
    end
endmodule : axf_core_model

/* bench/axf_status_props.sv */
// concurrent checks on the flag and start-allowed outputs of the status flag block
`timescale 1ns/1ps
module axf_status_props
    import axf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] start_request,
    input wire logic [1:0] start_allowed,
    input wire axf_motion_t [1:0] motion,
    input wire axf_flags_t [1:0] flags
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ack_from_start: assert property (
        $rose(flags[0].start_ack) |-> $past(motion[0].op_start, 2)) else $error("bad ack");
    a_ack_drops: assert property (
        $fell(start_request[0]) |-> ##[1:8] !flags[0].start_ack) else $error("ack stuck");
    a_busy_on_move: assert property (
        motion[0].op_start && motion[0].op_kind == AXF_OP_POS |-> ##2 flags[0].busy)
        else $error("no busy");
    a_abort_busy: assert property (
        motion[1].abort |-> ##2 !flags[1].busy) else $error("busy after abort");
    a_err_sets: assert property (
        motion[1].error_event |-> ##2 flags[1].error_flag) else $error("no error flag");
    a_cplt_cleared: assert property (
        motion[0].op_start |-> ##2 !flags[0].pos_complete) else $error("complete kept");
    a_spd_follow: assert property (
        flags[0].speed_change == $past(motion[0].speed_change)) else $error("speed change");
    a_aux_blocks: assert property (
        flags[0].aux_code_present ##1 flags[0].aux_code_present |-> !$past(start_allowed[0]))
        else $error("start allowed");
endmodule : axf_status_props

/* bench/tb.sv */
// self-checking bench for the axis status flag block with its core model
`timescale 1ns/1ps
module tb
    import axf_pkg::*;
;
    localparam int MS = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic pready, pslverr, e;
    logic [7:0] paddr = 8'h00;
    logic [7:0] run_len = 8'h04;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, q;
    logic [1:0] start_request = 2'h0;
    logic [1:0] clr = 2'h0;
    logic [1:0] start_go, start_allowed;
    axf_motion_t [1:0] inj = '0;
    axf_motion_t [1:0] motion;
    axf_flags_t [1:0] flags;
    axf_op_t kinds [2] = '{AXF_OP_POS, AXF_OP_ZRET};
    int fails = 0;
    int checked = 0;
    int n;
    int cplt_hi = 0;
    logic rdy = 1'b1;
    logic [1:0] mpg = 2'h0;
    // 125 mhz clock
    always #4 pclk = ~pclk;
    // cycles the current complete pulse has stood, sampled on settled values
    always @(negedge pclk) cplt_hi <= flags[0].pos_complete ? cplt_hi + 1 : 0;
    axf_status_flags #(.MS_CYC(MS), .SLOW_CYC(50)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .start_request, .aux_code_clear_req(clr), .mpg_enable(mpg), .station_ready(rdy),
        .motion, .start_go, .start_allowed, .flags);
    axf_core_model core (.pclk, .presetn, .start_go, .inj, .run_len, .motion);
    task summarize;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    // one apb transfer; pready is waited for, never assumed
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // waits on settled values at the falling edge, returns on a rising edge
    task wchk(input int a, input int b, input logic v, input int lim, input string m);
        repeat (lim) begin
            @(negedge pclk);
            if (flags[a][b] === v)
                break;
        end
        chk(flags[a][b], v, m);
        @(posedge pclk);
    endtask : wchk
    function automatic logic [31:0] cfg(input int d, input int c);
        return {c[15:0], d[15:0]};
    endfunction : cfg
    // watchdog far beyond the few hundred cycles the tests take
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        summarize;
    end
    // main sequence
    initial begin
        void'($urandom(32'hff9a));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, AXF_AX1_CFG_OFS, 32'h0);
        chk(q, cfg(0, 300), "cfg reset");
        apb(1'b1, AXF_AX1_CFG_OFS, cfg(0, 2));
        apb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0, "unmapped read");
        chk(e, 1'b1, "unmapped error");
        inj[1].error_event <= 1'b1;
        inj[1].abort <= 1'b1;
        @(posedge pclk);
        inj[1].error_event <= 1'b0;
        inj[1].abort <= 1'b0;
        wchk(1, 4, 1'b1, 4, "axis2 error");
        wchk(0, 4, 1'b0, 1, "axis1 error");
        apb(1'b1, AXF_CTRL_OFS, 32'h2);
        wchk(1, 4, 1'b0, 4, "axis2 error reset");
        $display("test regs and errors done");
        foreach (kinds[k]) begin
            inj[0].op_kind <= kinds[k];
            inj[0].speed_change <= 1'($urandom);
            run_len <= 8'($urandom_range(2, 12));
            start_request[0] <= 1'b1;
            wchk(0, 6, 1'b1, 12, "busy");
            wchk(0, 7, 1'b1, 4, "ack");
            start_request[0] <= 1'b0;
            wchk(0, 7, 1'b0, 10, "ack drop");
            wchk(0, 5, 1'b1, 20, "complete");
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (flags[0].pos_complete === 1'b1 && n < 200);
            chk(cplt_hi >= MS && cplt_hi <= 2 * MS, 1'b1, "complete time");
            chk(flags[0].busy, 1'b0, "busy after stop");
            chk(flags[0].aux_code_present, 1'b0, "aux on zero code");
            @(posedge pclk);
        end
        inj[0].op_kind <= AXF_OP_MPG;
        mpg <= 2'h1;
        start_request[0] <= 1'b1;
        wchk(0, 6, 1'b1, 12, "mpg busy");
        start_request[0] <= 1'b0;
        repeat (20) @(negedge pclk);
        chk(flags[0].busy, 1'b1, "busy held");
        @(posedge pclk);
        mpg <= 2'h0;
        wchk(0, 6, 1'b0, 12, "busy follows mpg");
        $display("test start cycles done");
        inj[0].op_kind <= AXF_OP_POS;
        inj[0].aux_code <= 16'($urandom_range(1, 65535));
        start_request[0] <= 1'b1;
        wchk(0, 3, 1'b1, 14, "aux at entry start");
        start_request[0] <= 1'b0;
        wchk(0, 6, 1'b0, 30, "move ends");
        start_request[0] <= 1'b1;
        wchk(0, 4, 1'b1, 12, "refused start");
        wchk(0, 7, 1'b0, 1, "no ack");
        apb(1'b0, AXF_AX1_CODE_OFS, 32'h0);
        chk(q[15:0], 16'h0218, "error code");
        start_request[0] <= 1'b0;
        clr[0] <= 1'b1;
        wchk(0, 3, 1'b0, 12, "aux cleared");
        clr[0] <= 1'b0;
        apb(1'b1, AXF_CTRL_OFS, 32'h1);
        wchk(0, 4, 1'b0, 4, "error reset");
        apb(1'b1, AXF_MODE_OFS, 32'h1);
        start_request[0] <= 1'b1;
        wchk(0, 6, 1'b1, 12, "busy");
        wchk(0, 3, 1'b0, 1, "aux early");
        wchk(0, 3, 1'b1, 30, "aux at completion");
        start_request[0] <= 1'b0;
        rdy <= 1'b0;
        wchk(0, 3, 1'b0, 12, "aux on ready low");
        $display("test aux code done");
        summarize;
    end
endmodule : tb
bind axf_status_flags axf_status_props u_props (.pclk, .presetn, .start_request,
    .start_allowed, .motion, .flags);
